// ===== logic/mahc_csr.sv
/*
 Control registers of a MAC: station address, group hash table and the
 PHY management command. Assumes the EEPROM loader delivers address bytes
 at power-on and a PHY management engine answers each cycle with done.
*/
// Design decision made here: the address-and-strobe port.
// Function
// - Upper address register holds address bits 47:32 low; top half reserved.
// - Lower address register holds address bits 31:0.
// - EEPROM loads address at power-on only when programmed EEPROM present.
// - EEPROM bytes 1..4 fill lower register LSB first; 5,6 fill upper.
// - Address compared in wire order, lower byte 0 is first received.
// - Software may overwrite address after initialization; new value used.
// - Six-bit hash index: top bit picks register, five bits pick bit.
// - Multicast accepted when selected hash bit is one, else rejected.
// - Pass-all-group control accepts every multicast frame.
// - Hash table is upper:lower 32-bit registers, both reset zero.
// - Command bits 10:6 give the PHY register index.
// - Bit 1 set writes PHY from data register; clear reads into it.
// - Busy stays one for the whole access and clears on completion.
// - Data register invalid during a read until busy clears.
// - Data register carries the 16-bit PHY value in its low bits.
`timescale 1ns/1ps
module mahc_csr
   import mahc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire mahc_pkg::mahc_bus_req_t busReq,
   output logic [31:0] busRdata,
   input wire logic eeLoadActive,
   input wire logic eeProgrammed,
   input wire mahc_pkg::mahc_ee_byte_t eeByte,
   input wire logic [47:0] rxDestAddr,
   input wire logic [5:0] rxHashIndex,
   input wire logic rxCheck,
   output logic stationMatch,
   output logic groupAccept,
   output mahc_pkg::mahc_mdio_req_t mdioReq,
   input wire logic mdioDone,
   input wire logic [15:0] mdioRdata,
   output logic mgmtBusy
);
   import mahc_pkg::*;

   logic rstSync1_reg, rstSync2_reg;
   logic rstN;
   logic [15:0] addrUp_reg;
   logic [31:0] addrLo_reg;
   logic [31:0] hashUp_reg, hashLo_reg;
   logic [15:0] cmd_reg;
   logic [15:0] data_reg;
   logic passAll_reg;
   logic [31:0] busRdata_reg;
   logic stationMatch_reg, groupAccept_reg;
   logic start_reg;
   mahc_mgmt_state_t mgState_reg;
   logic [63:0] hashTable;
   logic [47:0] stationAddr;
   logic wrUp, wrLo, wrCmd, wrData, cmdAccept;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end
   assign rstN = rstSync2_reg;

   assign wrUp = busReq.wr && busReq.addr == OFS_ADDR_UP;
   assign wrLo = busReq.wr && busReq.addr == OFS_ADDR_LO;
   assign wrCmd = busReq.wr && busReq.addr == OFS_MGMT_CMD;
   assign wrData = busReq.wr && busReq.addr == OFS_MGMT_DATA;
   assign cmdAccept = wrCmd && !cmd_reg[CMD_BUSY];

   // Station address: EEPROM load has priority while it runs
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         addrUp_reg <= RST_ADDR_UP;
         addrLo_reg <= RST_ADDR_LO;
      end else if (eeLoadActive) begin
         if (eeProgrammed && eeByte.valid) begin
            case (eeByte.addr)
               3'h1: addrLo_reg[7:0] <= eeByte.data;
               3'h2: addrLo_reg[15:8] <= eeByte.data;
               3'h3: addrLo_reg[23:16] <= eeByte.data;
               3'h4: addrLo_reg[31:24] <= eeByte.data;
               3'h5: addrUp_reg[7:0] <= eeByte.data;
               3'h6: addrUp_reg[15:8] <= eeByte.data;
               default: addrUp_reg <= addrUp_reg;
            endcase
         end
      end else begin
         if (wrUp) begin
            addrUp_reg <= busReq.wdata[15:0];
         end
         if (wrLo) begin
            addrLo_reg <= busReq.wdata;
         end
      end
   end

   // Hash table and filter control
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         hashUp_reg <= RST_HASH;
         hashLo_reg <= RST_HASH;
         passAll_reg <= 1'b0;
      end else if (busReq.wr) begin
         if (busReq.addr == OFS_HASH_UP) begin
            hashUp_reg <= busReq.wdata;
         end
         if (busReq.addr == OFS_HASH_LO) begin
            hashLo_reg <= busReq.wdata;
         end
         if (busReq.addr == OFS_FILT_CTRL) begin
            passAll_reg <= busReq.wdata[FILT_PASS_ALL];
         end
      end
   end

   assign hashTable = {hashUp_reg, hashLo_reg};
   // Wire order: first received byte sits in lower register bits 7:0
   assign stationAddr = {addrUp_reg[15:8], addrUp_reg[7:0],
      addrLo_reg[31:24], addrLo_reg[23:16], addrLo_reg[15:8],
      addrLo_reg[7:0]};

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         stationMatch_reg <= 1'b0;
         groupAccept_reg <= 1'b0;
      end else if (rxCheck) begin
         stationMatch_reg <= rxDestAddr == stationAddr;
         groupAccept_reg <= passAll_reg || hashTable[rxHashIndex];
      end
   end
   assign stationMatch = stationMatch_reg;
   assign groupAccept = groupAccept_reg;

   // Management command and sequencing
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cmd_reg <= 16'h0000;
         start_reg <= 1'b0;
         mgState_reg <= MG_IDLE;
      end else begin
         start_reg <= 1'b0;
         case (mgState_reg)
            MG_IDLE: begin
               if (cmdAccept) begin
                  cmd_reg <= busReq.wdata[15:0] & 16'hffc3;
                  if (busReq.wdata[CMD_BUSY]) begin
                     start_reg <= 1'b1;
                     mgState_reg <= MG_WAIT;
                  end
               end
            end
            MG_WAIT: begin
               if (mdioDone) begin
                  cmd_reg[CMD_BUSY] <= 1'b0;
                  mgState_reg <= MG_IDLE;
               end
            end
            default: mgState_reg <= MG_IDLE;
         endcase
      end
   end
   assign mgmtBusy = cmd_reg[CMD_BUSY];

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         data_reg <= 16'h0000;
      end else if (mgState_reg == MG_WAIT && mdioDone
            && !cmd_reg[CMD_WRITE]) begin
         data_reg <= mdioRdata;
      end else if (wrData && !cmd_reg[CMD_BUSY]) begin
         data_reg <= busReq.wdata[DATA_W-1:0];
      end
   end

   always_comb begin
      mdioReq.start = start_reg;
      mdioReq.write = cmd_reg[CMD_WRITE];
      mdioReq.phyAddr = cmd_reg[PA_MSB:PA_LSB];
      mdioReq.regIdx = cmd_reg[IDX_MSB:IDX_LSB];
      mdioReq.wdata = data_reg;
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         busRdata_reg <= 32'h00000000;
      end else if (busReq.rd) begin
         case (busReq.addr)
            OFS_FILT_CTRL: busRdata_reg <= {31'h0, passAll_reg};
            OFS_ADDR_UP: busRdata_reg <= {16'h0000, addrUp_reg};
            OFS_ADDR_LO: busRdata_reg <= addrLo_reg;
            OFS_HASH_UP: busRdata_reg <= hashUp_reg;
            OFS_HASH_LO: busRdata_reg <= hashLo_reg;
            OFS_MGMT_CMD: busRdata_reg <= {16'h0000, cmd_reg};
            OFS_MGMT_DATA: busRdata_reg <= {16'h0000, data_reg};
            default: busRdata_reg <= 32'h00000000;
         endcase
      end else begin
         busRdata_reg <= 32'h00000000;
      end
   end
   assign busRdata = busRdata_reg;

   sequence s_start;
      cmdAccept && busReq.wdata[CMD_BUSY];
   endsequence
   sequence s_busy_seen;
      ##1 mgmtBusy && mdioReq.start;
   endsequence

   AST_START_BUSY: assert property (@(posedge clock) disable iff (!rstN)
      s_start |-> s_busy_seen) else $error("start did not raise busy");
   AST_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && !mdioDone |=> mgmtBusy) else $error("busy dropped early");
   AST_BUSY_CLEAR: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && mdioDone |=> !mgmtBusy) else $error("busy not cleared");
   AST_READ_DATA: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && mdioDone && !cmd_reg[CMD_WRITE] |=>
      data_reg == $past(mdioRdata)) else $error("read data lost");
   AST_WRITE_STEADY: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && cmd_reg[CMD_WRITE] |=> $stable(data_reg))
      else $error("write data moved");
   AST_CMD_HOLD: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && !mdioDone |=> $stable(cmd_reg[IDX_MSB:IDX_LSB]))
      else $error("index changed while busy");
   AST_GROUP: assert property (@(posedge clock) disable iff (!rstN)
      rxCheck && !passAll_reg |=> groupAccept == $past(hashTable[rxHashIndex]))
      else $error("hash decision wrong");
   AST_PASS_ALL: assert property (@(posedge clock) disable iff (!rstN)
      rxCheck && passAll_reg |=> groupAccept)
      else $error("pass all ignored");
   AST_ADDR_WRITE: assert property (@(posedge clock) disable iff (!rstN)
      wrLo && !eeLoadActive |=> addrLo_reg == $past(busReq.wdata))
      else $error("address write lost");
   AST_UP_RSVD: assert property (@(posedge clock) disable iff (!rstN)
      busReq.rd && busReq.addr == OFS_ADDR_UP |=> busRdata[31:16] == 16'h0000)
      else $error("reserved bits nonzero");

   // Power-on load: each EEPROM byte lands in its own address byte
   sequence s_ee_take;
      eeLoadActive && eeProgrammed && eeByte.valid;
   endsequence

   AST_EE_BYTE1: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h1 |=>
      addrLo_reg[7:0] == $past(eeByte.data))
      else $error("byte 1 not loaded");
   AST_EE_BYTE2: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h2 |=>
      addrLo_reg[15:8] == $past(eeByte.data))
      else $error("byte 2 not loaded");
   AST_EE_BYTE3: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h3 |=>
      addrLo_reg[23:16] == $past(eeByte.data))
      else $error("byte 3 not loaded");
   AST_EE_BYTE4: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h4 |=>
      addrLo_reg[31:24] == $past(eeByte.data))
      else $error("byte 4 not loaded");
   AST_EE_BYTE5: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h5 |=>
      addrUp_reg[7:0] == $past(eeByte.data))
      else $error("byte 5 not loaded");
   AST_EE_BYTE6: assert property (@(posedge clock) disable iff (!rstN)
      s_ee_take and eeByte.addr == 3'h6 |=>
      addrUp_reg[15:8] == $past(eeByte.data))
      else $error("byte 6 not loaded");

   // Without a programmed EEPROM the address keeps its value
   AST_EE_SKIP: assert property (@(posedge clock) disable iff (!rstN)
      eeLoadActive && !eeProgrammed |=>
      $stable(addrLo_reg) && $stable(addrUp_reg))
      else $error("address moved without EEPROM");
   AST_EE_BLOCKS_BUS: assert property (@(posedge clock) disable iff (!rstN)
      eeLoadActive && !eeByte.valid |=>
      $stable(addrLo_reg) && $stable(addrUp_reg))
      else $error("bus write during load");
   AST_UP_WRITE: assert property (@(posedge clock) disable iff (!rstN)
      wrUp && !eeLoadActive |=> addrUp_reg == $past(busReq.wdata[15:0]))
      else $error("upper address write lost");

   // Hash registers take whole words
   AST_HASH_UP_WRITE: assert property (@(posedge clock) disable iff (!rstN)
      busReq.wr && busReq.addr == OFS_HASH_UP |=>
      hashUp_reg == $past(busReq.wdata))
      else $error("upper hash write lost");
   AST_HASH_LO_WRITE: assert property (@(posedge clock) disable iff (!rstN)
      busReq.wr && busReq.addr == OFS_HASH_LO |=>
      hashLo_reg == $past(busReq.wdata))
      else $error("lower hash write lost");

   // Station match compares all six bytes at once
   AST_MATCH: assert property (@(posedge clock) disable iff (!rstN)
      rxCheck |=> stationMatch == ($past(rxDestAddr) == $past(stationAddr)))
      else $error("station match wrong");

   // Reserved fields of the management registers read zero
   AST_CMD_RSVD: assert property (@(posedge clock) disable iff (!rstN)
      busReq.rd && busReq.addr == OFS_MGMT_CMD |=>
      busRdata[31:16] == 16'h0000 && busRdata[5:2] == 4'h0)
      else $error("command reserved bits nonzero");
   AST_DATA_RSVD: assert property (@(posedge clock) disable iff (!rstN)
      busReq.rd && busReq.addr == OFS_MGMT_DATA |=>
      busRdata[31:16] == 16'h0000)
      else $error("data reserved bits nonzero");
   AST_RD_IDLE: assert property (@(posedge clock) disable iff (!rstN)
      !busReq.rd |=> busRdata == 32'h00000000)
      else $error("read data outside its cycle");

   // Data register frozen while an access is in flight
   AST_DATA_BUSY: assert property (@(posedge clock) disable iff (!rstN)
      mgmtBusy && !mdioDone |=> $stable(data_reg))
      else $error("data changed while busy");

   // One start pulse per access, and only with busy set
   sequence s_start_pulse;
      mdioReq.start ##1 !mdioReq.start;
   endsequence
   AST_START_ONCE: assert property (@(posedge clock) disable iff (!rstN)
      mdioReq.start |-> s_start_pulse)
      else $error("start longer than one cycle");
   AST_START_BUSY_SET: assert property (@(posedge clock) disable iff (!rstN)
      mdioReq.start |-> mgmtBusy)
      else $error("start without busy");
endmodule

// ===== logic/mahc_pkg.sv
/*
 Package for the station address, group hash and PHY management registers.
 Assumes a plain register port with word indices as printed offsets.
*/
package mahc_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_ADDR_UP = 4'h2;
   localparam logic [3:0] OFS_ADDR_LO = 4'h3;
   localparam logic [3:0] OFS_HASH_UP = 4'h4;
   localparam logic [3:0] OFS_HASH_LO = 4'h5;
   localparam logic [3:0] OFS_MGMT_CMD = 4'h6;
   localparam logic [3:0] OFS_MGMT_DATA = 4'h7;
   localparam logic [3:0] OFS_FILT_CTRL = 4'h1;
   localparam logic [15:0] RST_ADDR_UP = 16'hffff;
   localparam logic [31:0] RST_ADDR_LO = 32'h0fffffff;
   localparam logic [31:0] RST_HASH = 32'h00000000;
   localparam int CMD_BUSY = 0;
   localparam int CMD_WRITE = 1;
   localparam int IDX_LSB = 6;
   localparam int IDX_MSB = 10;
   localparam int PA_LSB = 11;
   localparam int PA_MSB = 15;
   localparam int DATA_W = 16;
   localparam int FILT_PASS_ALL = 0;
   localparam logic [2:0] EE_FIRST = 3'h1;
   localparam logic [2:0] EE_LAST = 3'h6;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mahc_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [2:0] addr;
      logic [7:0] data;
   } mahc_ee_byte_t;

   typedef struct packed {
      logic start;
      logic write;
      logic [4:0] phyAddr;
      logic [4:0] regIdx;
      logic [15:0] wdata;
   } mahc_mdio_req_t;

   typedef enum logic [1:0] {MG_IDLE, MG_WAIT} mahc_mgmt_state_t;
endpackage

// ===== tb/mahc_phy_model.sv
/* Behavioural PHY management register set behind the management engine.
 Assumes one start pulse per access; done follows after 1 or 20 cycles. */
`timescale 1ns/1ps
module mahc_phy_model
   import mahc_pkg::*;
(
   input wire logic clock,
   input wire mahc_pkg::mahc_mdio_req_t mdioReq,
   input wire logic slow,
   output logic mdioDone,
   output logic [15:0] mdioRdata
);
   logic [15:0] regs [32];
   int cnt;
   initial begin
      mdioDone = 1'b0;
      mdioRdata = 16'h0;
      cnt = 0;
      for (int k = 0; k < 32; k++) begin
         regs[k] = 16'hc3a0 ^ 16'(k);
      end
   end
   // Read data is only valid beside done; otherwise it toggles
   always @(posedge clock) begin
      mdioDone <= 1'b0;
      mdioRdata <= ~mdioRdata;
      if (mdioReq.start) begin
         cnt <= slow ? 20 : 1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (cnt == 1) begin
         mdioDone <= 1'b1;
         if (mdioReq.write) begin
            regs[mdioReq.regIdx] <= mdioReq.wdata;
         end else begin
            mdioRdata <= regs[mdioReq.regIdx];
         end
      end
   end
endmodule

// ===== tb/tb_mahc_csr.sv
/* Self-checking bench for mahc_csr: registers, EEPROM load, filters, PHY.
 Assumes mahc_phy_model answers the management requests. */
`timescale 1ns/1ps
module tb_mahc_csr;
   import mahc_pkg::*;
   logic clock, rst_n, eeLoadActive, eeProgrammed, rxCheck, stationMatch;
   logic groupAccept, mdioDone, mgmtBusy, slow;
   mahc_bus_req_t busReq;
   mahc_ee_byte_t eeByte;
   mahc_mdio_req_t mdioReq;
   logic [31:0] busRdata, d, lo, hi;
   logic [63:0] ht;
   logic [47:0] rxDestAddr;
   logic [5:0] rxHashIndex;
   logic [15:0] mdioRdata, wv;
   int fails, comparisons, seed, i;
   mahc_csr i_mahc_csr (.clock(clock), .rst_n(rst_n), .busReq(busReq),
      .busRdata(busRdata), .eeLoadActive(eeLoadActive),
      .eeProgrammed(eeProgrammed), .eeByte(eeByte),
      .rxDestAddr(rxDestAddr), .rxHashIndex(rxHashIndex),
      .rxCheck(rxCheck), .stationMatch(stationMatch),
      .groupAccept(groupAccept), .mdioReq(mdioReq), .mdioDone(mdioDone),
      .mdioRdata(mdioRdata), .mgmtBusy(mgmtBusy));
   mahc_phy_model i_mahc_phy_model (.clock(clock), .mdioReq(mdioReq),
      .slow(slow), .mdioDone(mdioDone), .mdioRdata(mdioRdata));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [31:0] rstVal(logic [3:0] a);
      return a == OFS_ADDR_UP ? {16'h0, RST_ADDR_UP} :
         a == OFS_ADDR_LO ? RST_ADDR_LO : 32'h0;
   endfunction
   function automatic logic [31:0] cmd(logic [4:0] ix, logic [1:0] wb);
      return {16'h0, 5'h01, ix, 4'h0, wb};
   endfunction
   task automatic check(string n, logic [47:0] s, logic [47:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge clock);
      busReq.addr <= a;
      busReq.wdata <= v;
      busReq.wr <= 1'b1;
      @(posedge clock);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge clock);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clock);
      busReq.rd <= 1'b0;
      @(negedge clock);
      d = busRdata;
   endtask
   task automatic ee(logic [2:0] a, logic [7:0] v);
      @(posedge clock);
      eeByte <= '{1'b1, a, v};
      @(posedge clock);
      eeByte.valid <= 1'b0;
   endtask
   task automatic rx(logic [47:0] da, logic [5:0] ix);
      @(posedge clock);
      rxDestAddr <= da;
      rxHashIndex <= ix;
      rxCheck <= 1'b1;
      @(posedge clock);
      rxCheck <= 1'b0;
      @(negedge clock);
   endtask
   task automatic phy(logic [4:0] ix, logic w, logic intr);
      int n;
      wr(OFS_MGMT_CMD, cmd(ix, {w, 1'b1}));
      if (intr) begin
         wr(OFS_MGMT_CMD, cmd(~ix, 2'h3));
         wr(OFS_MGMT_DATA, 32'h5a5a);
      end
      rd(OFS_MGMT_CMD);
      check("busy", d[0], 1'b1);
      check("index", mdioReq.regIdx, ix);
      check("phyaddr", mdioReq.phyAddr, 5'h01);
      check("dir", mdioReq.write, w);
      n = 0;
      while (d[0] === 1'b1 && n < 60) begin
         rd(OFS_MGMT_CMD);
         n++;
      end
      check("cmd", d, cmd(ix, {w, 1'b0}));
   endtask
   task automatic final_report;
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      final_report;
   end
   initial begin
      seed = 32'h657674b0;
      rst_n = 1'b0;
      busReq = '0;
      eeByte = '0;
      eeLoadActive = 1'b1;
      eeProgrammed = 1'b0;
      rxDestAddr = '0;
      rxHashIndex = '0;
      rxCheck = 1'b0;
      slow = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (i = 0; i <= 8; i++) begin
         rd(i[3:0]);
         check("reset", d, rstVal(i[3:0]));
      end
      lo = $random(seed);
      hi = $random(seed);
      for (i = 1; i <= 6; i++) begin
         ee(i[2:0], i < 5 ? lo[8*(i-1)+: 8] : hi[8*(i-5)+: 8]);
      end
      rd(OFS_ADDR_LO);
      check("noload", d, RST_ADDR_LO);
      rd(OFS_ADDR_UP);
      check("noloadhi", d, {16'h0, RST_ADDR_UP});
      eeProgrammed <= 1'b1;
      for (i = 1; i <= 6; i++) begin
         ee(i[2:0], i < 5 ? lo[8*(i-1)+: 8] : hi[8*(i-5)+: 8]);
      end
      wr(OFS_ADDR_LO, 32'h0);
      rd(OFS_ADDR_LO);
      check("eelo", d, lo);
      rd(OFS_ADDR_UP);
      check("eehi", d, {16'h0, hi[15:0]});
      @(posedge clock);
      eeLoadActive <= 1'b0;
      wr(OFS_ADDR_UP, 32'hffffffff);
      rd(OFS_ADDR_UP);
      check("resv", d, 32'h0000ffff);
      lo = $random(seed);
      hi = $random(seed);
      wr(OFS_ADDR_LO, lo);
      wr(OFS_ADDR_UP, hi);
      rx({hi[15:0], lo}, 6'h0);
      check("match", stationMatch, 1'b1);
      rx({hi[15:8] ^ 8'h01, hi[7:0], lo}, 6'h0);
      check("sixth", stationMatch, 1'b0);
      rx({hi[15:0], lo[31:8], lo[7:0] ^ 8'h80}, 6'h0);
      check("first", stationMatch, 1'b0);
      ht = {$random(seed), $random(seed)};
      wr(OFS_HASH_UP, ht[63:32]);
      wr(OFS_HASH_LO, ht[31:0]);
      for (i = 0; i < 64; i++) begin
         rx(48'h1, i[5:0]);
         check("hash", groupAccept, ht[i]);
      end
      wr(OFS_HASH_UP, 32'h0);
      wr(OFS_FILT_CTRL, 32'h1 << FILT_PASS_ALL);
      rx(48'h1, 6'h3f);
      check("passall", groupAccept, 1'b1);
      wr(OFS_FILT_CTRL, 32'h0);
      rx(48'h1, 6'h3f);
      check("reject", groupAccept, 1'b0);
      for (i = 0; i < 4; i++) begin
         wv = $random(seed);
         slow <= i[0];
         wr(OFS_MGMT_DATA, {16'h0, wv});
         phy(i[4:0] + 5'h3, 1'b1, 1'b0);
         phy(i[4:0] + 5'h3, 1'b0, 1'b0);
         rd(OFS_MGMT_DATA);
         check("phydata", d, {16'h0, wv});
      end
      slow <= 1'b1;
      phy(5'h1f, 1'b0, 1'b1);
      rd(OFS_MGMT_DATA);
      check("phyinit", d, {16'h0, 16'hc3a0 ^ 16'h1f});
      final_report;
   end
endmodule
